//--- verilog/pos_params.svh
// constants for the out-of-band signalling sequencer and detector
// ==========================================================
// Notes on behaviour
// - idle carries D.C. idle, burst carries transitions
// - signals differ only by idle length
// - support COMSAS; COMINIT equals COMRESET
// - transmit six idle then burst pairs
// - bursts are repeated ALIGN (0) primitives
// - after sixth burst hold negation idle
// - bursts at G1, else lowest supported rate
// - G2 bursts carry twice the ALIGN count
// - report after four matching idle/burst pairs
// - more than four pairs is no error
// - no re-report before negation or other signal
// - detect ALIGN bursts at any lower rate
// - SATA support also detects D24.3 bursts
// - port selection: five COMINITs, chosen intervals
// - never spread-spectrum the transmit clock
// - SATA receiver tolerates spread-spectrum input
// - retime SATA receive data onto internal clock
// - recovered clock never drives transmit
// - transmitter tolerates clock tracking by device
`ifndef POS_PARAMS_SVH
`define POS_PARAMS_SVH

// ==========================================================
// clock and timing, times in ns, clock period in ps
`define POS_CLK_PERIOD_PS  25000
`define POS_BURST_NS       320
`define POS_IDLE_INIT_NS   960
`define POS_IDLE_WAKE_NS   320
`define POS_IDLE_SAS_NS    2880
`define POS_NEG_INIT_NS    4000
`define POS_NEG_WAKE_NS    2000
`define POS_NEG_SAS_NS     8000
`define POS_PS_INTA_NS     20000
`define POS_PS_INTB_NS     30000
`define POS_TOL_SHIFT      2
`define POS_ALIGN_SLOT_G1  2

// ==========================================================
// sequence counts
`define POS_TX_PAIRS       3'h6
`define POS_RX_PAIRS       3'h4
`define POS_PS_COUNT       3'h5

// ==========================================================
// register map (byte addresses) and fields
`define POS_CTRL_ADDR      4'h0
`define POS_STATUS_ADDR    4'h4
`define POS_CTRL_START     0
`define POS_CTRL_KIND_LO   1
`define POS_CTRL_PSMODE    3
`define POS_CTRL_PAT_LO    4
`define POS_CTRL_SATA      8
`define POS_ST_BUSY        0
`define POS_ST_RATEG2      1
`define POS_ST_KIND_LO     2
`define POS_ST_SEEN_LO     4

`endif

//--- verilog/pos_pkg.sv
// types shared by the out-of-band signalling block
package pos_pkg;

  typedef enum logic [1:0] {
    POS_NONE,
    POS_INIT,
    POS_WAKE,
    POS_SAS
  } pos_kind_t;

  typedef enum {
    TX_OFF,
    TX_GAP,
    TX_BURST,
    TX_NEG,
    TX_PSWAIT
  } pos_tx_state_t;

endpackage

//--- verilog/pos_retimer.sv
// two-stage retimer onto the internal clock
`timescale 1ns/1ps
`default_nettype none

module pos_retimer #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] dIn,
  output logic      [WIDTH-1:0] dOut
);

  logic [WIDTH-1:0] stage1Reg;

  // first stage feeds the second stage only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1Reg <= '0;
      dOut      <= '0;
    end
    else
    begin
      stage1Reg <= dIn;
      dOut      <= stage1Reg;
    end
  end

endmodule

`default_nettype wire

//--- verilog/pos_oob_core.sv
// out-of-band sequencer, detector and register slave
`timescale 1ns/1ps
`default_nettype none
`include "pos_params.svh"

module pos_oob_core #(
  parameter int CNT_W       = 16,
  parameter int DATA_W      = 20,
  parameter bit LOWEST_G1   = 1'b1,
  parameter int BURST_NS    = `POS_BURST_NS,
  parameter int IDLE_INIT_NS = `POS_IDLE_INIT_NS,
  parameter int IDLE_WAKE_NS = `POS_IDLE_WAKE_NS,
  parameter int IDLE_SAS_NS  = `POS_IDLE_SAS_NS,
  parameter int NEG_INIT_NS  = `POS_NEG_INIT_NS,
  parameter int NEG_WAKE_NS  = `POS_NEG_WAKE_NS,
  parameter int NEG_SAS_NS   = `POS_NEG_SAS_NS,
  parameter int PS_INTA_NS   = `POS_PS_INTA_NS,
  parameter int PS_INTB_NS   = `POS_PS_INTB_NS
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // avalon-mm slave
  input  wire logic [3:0]        avsAddress,
  input  wire logic              avsRead,
  input  wire logic              avsWrite,
  input  wire logic [31:0]       avsWriteData,
  input  wire logic [3:0]        avsByteEnable,
  output logic      [31:0]       avsReadData,
  output logic                   avsWaitRequest,
  // transmit link
  output logic                   txIdle,
  output logic                   txAlign,
  output logic                   txRateG2,
  // receive link
  input  wire logic              rxAlignIn,
  input  wire logic              rxD243In,
  input  wire logic [DATA_W-1:0] rxDataIn,
  output logic      [DATA_W-1:0] rxDataOut,
  // detection events
  output logic                   detPulse,
  output pos_pkg::pos_kind_t     detKind
);
  import pos_pkg::*;

  // ==========================================================
  // derived cycle counts
  localparam int PER = `POS_CLK_PERIOD_PS;
  localparam int BURST_C  = (BURST_NS * 1000 + PER - 1) / PER;
  localparam int IINIT_C  = (IDLE_INIT_NS * 1000 + PER - 1) / PER;
  localparam int IWAKE_C  = (IDLE_WAKE_NS * 1000 + PER - 1) / PER;
  localparam int ISAS_C   = (IDLE_SAS_NS * 1000 + PER - 1) / PER;
  localparam int NINIT_C  = (NEG_INIT_NS * 1000 + PER - 1) / PER;
  localparam int NWAKE_C  = (NEG_WAKE_NS * 1000 + PER - 1) / PER;
  localparam int NSAS_C   = (NEG_SAS_NS * 1000 + PER - 1) / PER;
  localparam int PSA_C    = (PS_INTA_NS * 1000 + PER - 1) / PER;
  localparam int PSB_C    = (PS_INTB_NS * 1000 + PER - 1) / PER;
  localparam int TS       = `POS_TOL_SHIFT;
  localparam logic [CNT_W-1:0] BURST_END = CNT_W'(BURST_C - 1);
  localparam logic [1:0] SLOT_G1 = 2'(`POS_ALIGN_SLOT_G1 - 1);

  // idle timing for each signal, in clock cycles rounded up
  function automatic logic [CNT_W-1:0] idleCyc(input pos_kind_t k);
    unique case (k)
      POS_WAKE: idleCyc = CNT_W'(IWAKE_C);
      POS_SAS:  idleCyc = CNT_W'(ISAS_C);
      default:  idleCyc = CNT_W'(IINIT_C);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] negCyc(input pos_kind_t k);
    unique case (k)
      POS_WAKE: negCyc = CNT_W'(NWAKE_C);
      POS_SAS:  negCyc = CNT_W'(NSAS_C);
      default:  negCyc = CNT_W'(NINIT_C);
    endcase
  endfunction

  // the tolerance window absorbs spread-spectrum drift on receive
  function automatic logic inWin(input logic [CNT_W-1:0] n, input int c);
    inWin = (n >= CNT_W'(c - (c >> TS))) && (n <= CNT_W'(c + (c >> TS)));
  endfunction

  // ==========================================================
  // register state
  logic          ackReg;
  logic          sataReg;
  logic          psModeReg;
  logic [3:0]    psPatReg;
  pos_kind_t     txKindReg;
  logic [2:0]    seenReg;
  pos_kind_t     lastKindReg;
  pos_tx_state_t txStateReg;
  logic [CNT_W-1:0] txTimerReg;
  logic [CNT_W-1:0] psTimerReg;
  logic [2:0]    txPairReg;
  logic [2:0]    psLeftReg;
  logic [1:0]    slotReg;
  logic          wrCtrl;
  logic          wrStatus;
  logic          startCmd;
  logic [2:0]    seenSet;

  // ==========================================================
  // avalon slave: one wait state, then the answer
  assign avsWaitRequest = (avsRead | avsWrite) & ~ackReg;
  assign wrCtrl   = avsWrite & ackReg & (avsAddress == `POS_CTRL_ADDR);
  assign wrStatus = avsWrite & ackReg & (avsAddress == `POS_STATUS_ADDR);
  assign startCmd = wrCtrl & avsByteEnable[0]
                  & avsWriteData[`POS_CTRL_START] & (txStateReg == TX_OFF);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ackReg <= 1'b0;
    else
      ackReg <= (avsRead | avsWrite) & ~ackReg;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      avsReadData <= 32'h0;
    else if (avsRead & ~ackReg)
    begin
      avsReadData <= 32'h0;
      if (avsAddress == `POS_CTRL_ADDR)
      begin
        avsReadData[`POS_CTRL_KIND_LO +: 2] <= txKindReg;
        avsReadData[`POS_CTRL_PSMODE]       <= psModeReg;
        avsReadData[`POS_CTRL_PAT_LO +: 4]  <= psPatReg;
        avsReadData[`POS_CTRL_SATA]         <= sataReg;
      end
      else if (avsAddress == `POS_STATUS_ADDR)
      begin
        avsReadData[`POS_ST_BUSY]          <= txStateReg != TX_OFF;
        avsReadData[`POS_ST_RATEG2]        <= txRateG2;
        avsReadData[`POS_ST_KIND_LO +: 2]  <= lastKindReg;
        avsReadData[`POS_ST_SEEN_LO +: 3]  <= seenReg;
      end
    end
  end

  // configuration is frozen while a sequence runs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      txKindReg <= POS_INIT;
      psModeReg <= 1'b0;
      psPatReg  <= 4'h0;
      sataReg   <= 1'b0;
    end
    else if (wrCtrl && txStateReg == TX_OFF)
    begin
      if (avsByteEnable[0])
      begin
        txKindReg <= pos_kind_t'(avsWriteData[`POS_CTRL_KIND_LO +: 2]);
        psModeReg <= avsWriteData[`POS_CTRL_PSMODE];
        psPatReg  <= avsWriteData[`POS_CTRL_PAT_LO +: 4];
      end
      if (avsByteEnable[1])
        sataReg <= avsWriteData[`POS_CTRL_SATA];
    end
  end

  // seen flags: write one to clear, a new detection wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      seenReg <= 3'h0;
    else if (wrStatus && avsByteEnable[0])
      seenReg <= (seenReg & ~avsWriteData[`POS_ST_SEEN_LO +: 3]) | seenSet;
    else
      seenReg <= seenReg | seenSet;
  end

  // ==========================================================
  // transmit sequencer, clocked only by the local clock
  // no recovered clock enters here and the local clock is not
  // modulated, so the far end may track it freely
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      txRateG2 <= 1'b0;
    else
      txRateG2 <= ~LOWEST_G1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      txStateReg <= TX_OFF;
      txTimerReg <= '0;
      txPairReg  <= 3'h0;
      psLeftReg  <= 3'h0;
    end
    else
    begin
      txTimerReg <= txTimerReg + 1'b1;
      unique case (txStateReg)
        TX_OFF:
          if (startCmd)
          begin
            txStateReg <= TX_GAP;
            txTimerReg <= '0;
            txPairReg  <= 3'h0;
            psLeftReg  <= `POS_PS_COUNT - 3'h1;
          end
        TX_GAP:
          if (txTimerReg == idleCyc(psModeReg ? POS_INIT : txKindReg) - 1'b1)
          begin
            txStateReg <= TX_BURST;
            txTimerReg <= '0;
          end
        TX_BURST:
          if (txTimerReg == BURST_END)
          begin
            txTimerReg <= '0;
            txPairReg  <= txPairReg + 3'h1;
            if (txPairReg == `POS_TX_PAIRS - 3'h1)
              txStateReg <= TX_NEG;
            else
              txStateReg <= TX_GAP;
          end
        TX_NEG:
          if (txTimerReg == negCyc(psModeReg ? POS_INIT : txKindReg) - 1'b1)
          begin
            txTimerReg <= '0;
            if (psModeReg && psLeftReg != 3'h0)
              txStateReg <= TX_PSWAIT;
            else
              txStateReg <= TX_OFF;
          end
        TX_PSWAIT:
          // interval runs from the first burst of the last COMINIT
          if (psTimerReg >= (psPatReg[2'(psLeftReg - 3'h1)] ?
                             CNT_W'(PSB_C) : CNT_W'(PSA_C)))
          begin
            txStateReg <= TX_GAP;
            txTimerReg <= '0;
            txPairReg  <= 3'h0;
            psLeftReg  <= psLeftReg - 3'h1;
          end
      endcase
    end
  end

  // port-selection interval timer, restarted at each first burst of a COMINIT
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      psTimerReg <= '0;
    else if (txStateReg == TX_GAP && txPairReg == 3'h0
             && txTimerReg == idleCyc(POS_INIT) - 1'b1)
      psTimerReg <= '0;
    else if (psTimerReg != '1)
      psTimerReg <= psTimerReg + 1'b1;
  end

  // ALIGN slots: G2 slots are half as long, so twice as many fit
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      slotReg <= 2'h0;
      txAlign <= 1'b0;
      txIdle  <= 1'b1;
    end
    else
    begin
      txIdle  <= txStateReg != TX_BURST;
      txAlign <= 1'b0;
      if (txStateReg != TX_BURST)
        slotReg <= 2'h0;
      else if (txRateG2 || slotReg == SLOT_G1)
      begin
        slotReg <= 2'h0;
        txAlign <= 1'b1;
      end
      else
        slotReg <= slotReg + 2'h1;
    end
  end

  // ==========================================================
  // receive path
  logic [DATA_W+1:0] rxSync;
  logic              rxBurst;
  logic              rxBurstPrev;
  logic [CNT_W-1:0]  idleCntReg;
  logic [2:0]        pairCntReg;
  logic [2:0]        pairNext;
  pos_kind_t         pairKindReg;
  pos_kind_t         reportedReg;
  pos_kind_t         cls;

  pos_retimer #(
    .WIDTH (DATA_W + 2)
  ) u_retimer (
    .clk   (clk),
    .rst_n (rst_n),
    .dIn   ({rxAlignIn, rxD243In, rxDataIn}),
    .dOut  (rxSync)
  );

  assign rxDataOut = rxSync[DATA_W-1:0];
  // any-rate ALIGN envelope, D24.3 only with SATA support
  assign rxBurst = rxSync[DATA_W+1]
                 | (sataReg & rxSync[DATA_W]);

  // idle length alone selects the signal kind
  always_comb
  begin
    cls = POS_NONE;
    if (inWin(idleCntReg, IWAKE_C))
      cls = POS_WAKE;
    else if (inWin(idleCntReg, IINIT_C))
      cls = POS_INIT;
    else if (inWin(idleCntReg, ISAS_C))
      cls = POS_SAS;
  end

  always_comb
  begin
    pairNext = 3'h1;
    if (cls == POS_NONE)
      pairNext = 3'h0;
    else if (cls == pairKindReg)
      pairNext = (pairCntReg == 3'h7) ? pairCntReg
                                      : pairCntReg + 3'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rxBurstPrev <= 1'b0;
      // saturated, so the first burst after reset makes no pair
      idleCntReg  <= '1;
    end
    else
    begin
      rxBurstPrev <= rxBurst;
      if (rxBurst)
        idleCntReg <= '0;
      else if (idleCntReg != '1)
        idleCntReg <= idleCntReg + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pairCntReg  <= 3'h0;
      pairKindReg <= POS_NONE;
      reportedReg <= POS_NONE;
      lastKindReg <= POS_NONE;
      detPulse    <= 1'b0;
      detKind     <= POS_NONE;
      seenSet     <= 3'h0;
    end
    else
    begin
      detPulse <= 1'b0;
      seenSet  <= 3'h0;
      if (rxBurst && !rxBurstPrev)
      begin
        pairCntReg  <= pairNext;
        pairKindReg <= cls;
        if (pairNext == `POS_RX_PAIRS && reportedReg != cls)
        begin
          detPulse    <= 1'b1;
          detKind     <= cls;
          reportedReg <= cls;
          lastKindReg <= cls;
          seenSet     <= 3'h1 << (2'(cls) - 2'h1);
        end
      end
      else if (!rxBurst && reportedReg != POS_NONE
               && idleCntReg >= negCyc(reportedReg))
      begin
        reportedReg <= POS_NONE;
        pairCntReg  <= 3'h0;
      end
    end
  end

  // ==========================================================
  // checks
  tx_burst_only_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    txAlign |-> !txIdle && $past(txStateReg) == TX_BURST)
    else $error("align sent outside a burst");

  tx_six_pairs_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (txStateReg == TX_NEG && $past(txStateReg) == TX_BURST)
      |-> txPairReg == `POS_TX_PAIRS)
    else $error("negation began without six pairs");

  tx_neg_len_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($past(txStateReg) == TX_NEG && txStateReg != TX_NEG)
      |-> $past(txTimerReg)
          == negCyc(psModeReg ? POS_INIT : txKindReg) - 1'b1)
    else $error("negation idle of wrong length");

  tx_g1_spacing_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (txAlign && !txRateG2) |=> !txAlign)
    else $error("g1 aligns too dense");

  tx_rate_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> txRateG2 == !LOWEST_G1)
    else $error("burst rate above lowest supported rate");

  rx_four_pairs_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    detPulse |-> pairCntReg == `POS_RX_PAIRS && detKind != POS_NONE)
    else $error("report without four pairs");

  rx_no_repeat_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    detPulse |-> $past(reportedReg) != detKind && reportedReg == detKind)
    else $error("same signal reported twice");

  rx_pulse_one_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    detPulse |=> !detPulse)
    else $error("detection pulse longer than one cycle");

  ps_count_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (psModeReg && $past(txStateReg) == TX_NEG && txStateReg == TX_OFF)
      |-> psLeftReg == 3'h0)
    else $error("port selection ended early");

endmodule

`default_nettype wire

//--- dv/pos_phy_model.sv
// far-end phy model that sends out-of-band bursts towards the block
`timescale 1ns/1ps
`default_nettype none

module pos_phy_model (
  // clock
  input  wire logic clk,
  // squelch activity seen by the receiver
  output logic      rxAlign,
  output logic      rxD243
);
  initial
  begin
    rxAlign = 1'b0;
    rxD243  = 1'b0;
  end

  // ==========================================================
  // burst generator
  // n pairs: idle cycles of silence, then a 13-cycle burst
  task automatic send(input bit useD243, input int idle, input int n);
    for (int i = 0; i < n; i++)
    begin
      repeat (idle) @(posedge clk);
      if (useD243)
        rxD243 <= 1'b1;
      else
        rxAlign <= 1'b1;
      repeat (13) @(posedge clk);
      rxAlign <= 1'b0;
      rxD243  <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

//--- dv/pos_oob_core_test.sv
// self-checking bench for the out-of-band sequencer and detector
`timescale 1ns/1ps
`default_nettype none

module pos_oob_core_test;
  import pos_pkg::*;
  localparam int INTA = 600;
  localparam int INTB = 800;

  // ==========================================================
  // signals
  logic        clk            = 1'b0;
  logic        rst_n          = 1'b0;
  logic [3:0]  avsAddress     = 4'h0;
  logic        avsRead        = 1'b0;
  logic        avsWrite       = 1'b0;
  logic [31:0] avsWriteData   = 32'h0;
  logic [3:0]  avsByteEnable  = 4'hf;
  logic [19:0] rxDataIn       = 20'h0;
  logic [31:0] avsReadData;
  logic        avsWaitRequest;
  logic        txIdle;
  logic        txAlign;
  logic        txRateG2;
  logic        rxAlign;
  logic        rxD243;
  logic [19:0] rxDataOut;
  logic        detPulse;
  pos_kind_t   detKind;
  int          error_cnt      = 0;
  int          compares       = 0;
  int          seed           = 32'ha5a28dcc;
  int          cycles         = 0;
  int          idleCyc[4]     = '{39, 39, 13, 116};
  int          gapLen         = 1000;
  int          burstLen       = 0;
  int          alignCnt       = 0;
  int          bursts         = 0;
  int          expGap         = 0;
  int          lastStart      = 0;
  int          e;
  logic [31:0] expW;
  logic [31:0] rdLast;
  logic [3:0]  pat;
  logic [19:0] d1;
  logic [19:0] d2;
  logic [31:0] rdQ[$];
  pos_kind_t   kindQ[$];
  int          gapQ[$];

  always #12.5 clk = ~clk;

  // negation and port-select times shrunk to keep the run short
  pos_oob_core #(
    .NEG_INIT_NS (2000),
    .NEG_WAKE_NS (1000),
    .NEG_SAS_NS  (4000),
    .PS_INTA_NS  (15000),
    .PS_INTB_NS  (20000)
  ) i_pos_oob_core (
    .clk            (clk),
    .rst_n          (rst_n),
    .avsAddress     (avsAddress),
    .avsRead        (avsRead),
    .avsWrite       (avsWrite),
    .avsWriteData   (avsWriteData),
    .avsByteEnable  (avsByteEnable),
    .avsReadData    (avsReadData),
    .avsWaitRequest (avsWaitRequest),
    .txIdle         (txIdle),
    .txAlign        (txAlign),
    .txRateG2       (txRateG2),
    .rxAlignIn      (rxAlign),
    .rxD243In       (rxD243),
    .rxDataIn       (rxDataIn),
    .rxDataOut      (rxDataOut),
    .detPulse       (detPulse),
    .detKind        (detKind)
  );

  pos_phy_model i_pos_phy_model (
    .clk     (clk),
    .rxAlign (rxAlign),
    .rxD243  (rxD243)
  );

  // ==========================================================
  // tasks
  task automatic finish_test();
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is seen low, then released
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    avsAddress   <= a;
    avsWriteData <= d;
    avsWrite     <= wr;
    avsRead      <= !wr;
    @(posedge clk);
    while (avsWaitRequest !== 1'b0)
      @(posedge clk);
    rdLast = avsReadData;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  // polls busy without a note, so the monitor skips these reads
  task automatic wait_done(input int n);
    do
      bus(1'b0, 4'h4, 32'h0);
    while (rdLast[0] !== 1'b0);
    check(bursts, n);
    bursts = 0;
    repeat (200) @(posedge clk);
  endtask

  task automatic grp(input bit d, input int k, input int lead,
                     input int n, input bit exp);
    if (exp)
      kindQ.push_back(pos_kind_t'(k));
    i_pos_phy_model.send(d, lead, 1);
    i_pos_phy_model.send(d, idleCyc[k], n);
    repeat (10) @(posedge clk);
    check(kindQ.size(), 0);
  endtask

  // ==========================================================
  // monitor: pre-edge values, oldest note compared first
  always @(posedge clk)
  begin
    cycles++;
    rxDataIn <= 20'($random(seed));
    if (cycles > 40000)
    begin
      error_cnt++;
      finish_test();
    end
    else if (rst_n === 1'b1)
    begin
      if (avsRead === 1'b1 && avsWaitRequest === 1'b0 && rdQ.size() > 0)
        check(avsReadData, rdQ.pop_front());
      if (detPulse !== 1'b0)
      begin
        expW = 32'hffff_ffff;
        if (kindQ.size() > 0)
          expW = {30'h0, kindQ.pop_front()};
        check({30'h0, detKind}, expW);
      end
      if (cycles > 30)
        check(rxDataOut, d2);
      d2 = d1;
      d1 = rxDataIn;
      if (txIdle === 1'b0)
      begin
        if (burstLen == 0)
        begin
          bursts++;
          if (gapLen < 150)
            check(gapLen, expGap);
          else
          begin
            if (lastStart > 0 && gapQ.size() > 0)
            begin
              e = gapQ.pop_front();
              e = cycles - lastStart - e;
              check(e >= 0 && e <= 45, 1);
            end
            lastStart = cycles;
          end
        end
        burstLen++;
        gapLen = 0;
        if (txAlign === 1'b1)
          alignCnt++;
      end
      else
      begin
        if (burstLen > 0)
        begin
          check(burstLen, 13);
          check(alignCnt == 6 || alignCnt == 7, 1);
          check(txRateG2, 0);
        end
        if (txAlign !== 1'b0)
          check(txAlign, 0);
        burstLen = 0;
        alignCnt = 0;
        gapLen++;
      end
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(txIdle, 1);
    check(detKind, 0);
    rd(4'h0, 32'h2);
    rd(4'h4, 32'h0);
    bus(1'b1, 4'hc, 32'hffff_ffff);
    rd(4'hc, 32'h0);
    for (int k = 1; k < 4; k++)
    begin
      expGap = idleCyc[k];
      bus(1'b1, 4'h0, 32'h1 | (k << 1));
      rd(4'h4, 32'h1);
      bus(1'b1, 4'h0, 32'h7);
      rd(4'h0, k << 1);
      wait_done(6);
    end
    // random gap pattern, highest bit chooses the first interval
    pat = 4'($random(seed));
    for (int r = 4; r > 0; r--)
      gapQ.push_back(pat[r-1] ? INTB : INTA);
    lastStart = 0;
    expGap = 39;
    bus(1'b1, 4'h0, {24'h0, pat, 4'hb});
    wait_done(30);
    grp(1'b0, 1, 300, 6, 1'b1);
    grp(1'b0, 1, 60, 4, 1'b0);
    grp(1'b0, 1, 300, 4, 1'b1);
    grp(1'b0, 2, 300, 4, 1'b1);
    grp(1'b0, 3, 300, 4, 1'b1);
    grp(1'b0, 1, 60, 4, 1'b1);
    grp(1'b1, 2, 300, 4, 1'b0);
    // lane 1 only: the SATA bit lands, the start in lane 0 must not
    avsByteEnable <= 4'h2;
    bus(1'b1, 4'h0, 32'h1ff);
    avsByteEnable <= 4'hf;
    rd(4'h0, {23'h0, 1'b1, pat, 4'ha});
    grp(1'b1, 2, 300, 4, 1'b1);
    rd(4'h4, 32'h78);
    bus(1'b1, 4'h4, 32'h70);
    rd(4'h4, 32'h8);
    finish_test();
  end
endmodule

`default_nettype wire
